/* hw/iplr_regs.sv */
// Register access over Wishbone was decided locally.
`timescale 1ns/10ps
module iplr_regs
  import iplr_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [IPLR_ADR_W-1:0] adr_i,
  input  wire logic [IPLR_SEL_W-1:0] sel_i,
  input  wire logic [IPLR_DAT_W-1:0] dat_i,
  output logic      [IPLR_DAT_W-1:0] dat_o,
  output logic                       ack_o,
  output logic                       breakpoint0_en_o,
  output logic      [1:0]            breakpoint0_level_o,
  output logic                       step_counter_en_o,
  output logic      [1:0]            step_counter_level_o,
  output logic                       debug_rx_full_en_o,
  output logic      [1:0]            debug_rx_full_level_o,
  output logic                       debug_tx_empty_en_o,
  output logic      [1:0]            debug_tx_empty_level_o,
  output logic                       trace_buffer_en_o,
  output logic      [1:0]            trace_buffer_level_o,
  output logic                       flash_buffers_empty_en_o,
  output logic      [1:0]            flash_buffers_empty_level_o,
  output logic                       flash_cmd_done_en_o,
  output logic      [1:0]            flash_cmd_done_level_o,
  output logic                       flash_fault_en_o,
  output logic      [1:0]            flash_fault_level_o,
  output logic                       pll_unlocked_en_o,
  output logic      [1:0]            pll_unlocked_level_o,
  output logic                       low_voltage_en_o,
  output logic      [1:0]            low_voltage_level_o,
  output logic                       ext_pin_b_en_o,
  output logic      [1:0]            ext_pin_b_level_o,
  output logic                       ext_pin_a_en_o,
  output logic      [1:0]            ext_pin_a_level_o,
  output logic                       port_d_en_o,
  output logic      [1:0]            port_d_level_o,
  output logic                       port_e_en_o,
  output logic      [1:0]            port_e_level_o,
  output logic                       port_f_en_o,
  output logic      [1:0]            port_f_level_o,
  output logic                       can_msgbuf_en_o,
  output logic      [1:0]            can_msgbuf_level_o,
  output logic                       can_wake_en_o,
  output logic      [1:0]            can_wake_level_o,
  output logic                       can_fault_en_o,
  output logic      [1:0]            can_fault_level_o,
  output logic                       can_busoff_en_o,
  output logic      [1:0]            can_busoff_level_o
);

  // ==========================================================================
  // Bus slave
  logic [IPLR_IDX_W-1:0] adr_idx;
  logic                  take;
  logic                  wr_take;
  logic [IPLR_DAT_W-1:0] next_dat;
  logic [IPLR_NDBG-1:0]  dbg_en;
  logic [1:0]            dbg_lvl [IPLR_NDBG];
  logic [IPLR_NPER-1:0]  per_en;
  logic [1:0]            per_lvl [IPLR_NPER];

  assign adr_idx = adr_i[IPLR_ADR_W-1:2];
  assign take    = cyc_i && stb_i && !ack_o;
  assign wr_take = take && we_i;

  // The ack is registered, so every access costs two cycles; this keeps the
  // read mux off the bus path at the price of half the throughput.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= take;
    end
  end

  // Unmapped indices answer normally with zero data; nothing decodes there.
  always_comb begin
    next_dat = IPLR_DAT_ZERO;
    for (int i = 0; i < IPLR_NDBG; i++) begin
      if (adr_idx == IPLR_DBG_REG[i]) begin
        next_dat[IPLR_DBG_LSB[i] +: 2] = iplr_dbg_enc(dbg_en[i], dbg_lvl[i]);
      end
    end
    for (int i = 0; i < IPLR_NPER; i++) begin
      if (adr_idx == IPLR_PER_REG[i]) begin
        next_dat[IPLR_PER_LSB[i] +: 2] = iplr_per_enc(per_en[i], per_lvl[i]);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= IPLR_DAT_ZERO;
    end else if (take && !we_i) begin
      dat_o <= next_dat;
    end
  end

  // ==========================================================================
  // Priority fields
  // Only the decoded enable and level are stored; the read value is rebuilt
  // from them, so reserved bits have no storage and cannot be written.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < IPLR_NDBG; i++) begin
      if (rst_i) begin
        dbg_en[i]  <= 1'b0;
        dbg_lvl[i] <= IPLR_LVL_RST;
      end else if (wr_take && adr_idx == IPLR_DBG_REG[i]
                   && sel_i[IPLR_DBG_LSB[i] / IPLR_LANE]) begin
        dbg_en[i]  <= dat_i[IPLR_DBG_LSB[i] +: 2] != IPLR_FIELD_OFF;
        dbg_lvl[i] <= dat_i[IPLR_DBG_LSB[i] +: 2];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < IPLR_NPER; i++) begin
      if (rst_i) begin
        per_en[i]  <= 1'b0;
        per_lvl[i] <= IPLR_LVL_RST;
      end else if (wr_take && adr_idx == IPLR_PER_REG[i]
                   && sel_i[IPLR_PER_LSB[i] / IPLR_LANE]) begin
        per_en[i]  <= dat_i[IPLR_PER_LSB[i] +: 2] != IPLR_FIELD_OFF;
        per_lvl[i] <= iplr_per_dec(dat_i[IPLR_PER_LSB[i] +: 2]);
      end
    end
  end

  // ==========================================================================
  // Levels toward the arbiter
  assign breakpoint0_en_o            = dbg_en[0];
  assign breakpoint0_level_o         = dbg_lvl[0];
  assign step_counter_en_o           = dbg_en[1];
  assign step_counter_level_o        = dbg_lvl[1];
  assign debug_rx_full_en_o          = dbg_en[2];
  assign debug_rx_full_level_o       = dbg_lvl[2];
  assign debug_tx_empty_en_o         = dbg_en[3];
  assign debug_tx_empty_level_o      = dbg_lvl[3];
  assign trace_buffer_en_o           = dbg_en[4];
  assign trace_buffer_level_o        = dbg_lvl[4];
  assign flash_buffers_empty_en_o    = per_en[0];
  assign flash_buffers_empty_level_o = per_lvl[0];
  assign flash_cmd_done_en_o         = per_en[1];
  assign flash_cmd_done_level_o      = per_lvl[1];
  assign flash_fault_en_o            = per_en[2];
  assign flash_fault_level_o         = per_lvl[2];
  assign pll_unlocked_en_o           = per_en[3];
  assign pll_unlocked_level_o        = per_lvl[3];
  assign low_voltage_en_o            = per_en[4];
  assign low_voltage_level_o         = per_lvl[4];
  assign ext_pin_b_en_o              = per_en[5];
  assign ext_pin_b_level_o           = per_lvl[5];
  assign ext_pin_a_en_o              = per_en[6];
  assign ext_pin_a_level_o           = per_lvl[6];
  assign port_d_en_o                 = per_en[7];
  assign port_d_level_o              = per_lvl[7];
  assign port_e_en_o                 = per_en[8];
  assign port_e_level_o              = per_lvl[8];
  assign port_f_en_o                 = per_en[9];
  assign port_f_level_o              = per_lvl[9];
  assign can_msgbuf_en_o             = per_en[10];
  assign can_msgbuf_level_o          = per_lvl[10];
  assign can_wake_en_o               = per_en[11];
  assign can_wake_level_o            = per_lvl[11];
  assign can_fault_en_o              = per_en[12];
  assign can_fault_level_o           = per_lvl[12];
  assign can_busoff_en_o             = per_en[13];
  assign can_busoff_level_o          = per_lvl[13];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Checked on the first edge after release, since the default disable
  // would swallow any attempt that starts while reset is still high.
  property p_reset_off;
    @(posedge clk_i) $fell(rst_i)
      |-> dbg_en == '0 && per_en == '0 && !ack_o && dat_o == IPLR_DAT_ZERO;
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("A source is enabled right after reset.");

  property p_dbg_nonzero;
    step_counter_en_o |-> step_counter_level_o != 2'h0;
  endproperty
  a_dbg_nonzero: assert property (p_dbg_nonzero)
    else $error("Debug source enabled at level zero.");

  property p_per_max;
    can_wake_en_o |-> can_wake_level_o != 2'h3;
  endproperty
  a_per_max: assert property (p_per_max)
    else $error("Peripheral source enabled at level three.");

  property p_bp_write;
    wr_take && adr_idx == IPLR_DEBUG_BREAK_STEP_PRIORITY && sel_i[1]
      |=> breakpoint0_level_o == $past(dat_i[13:12])
          && breakpoint0_en_o == ($past(dat_i[13:12]) != 2'h0);
  endproperty
  a_bp_write: assert property (p_bp_write)
    else $error("Breakpoint level does not follow the write.");

  property p_pin_a_write;
    wr_take && adr_idx == IPLR_FLASH_CLOCK_SUPPLY_PIN_PRIORITY && sel_i[0]
      && dat_i[1:0] == 2'h1
      |=> ext_pin_a_en_o && ext_pin_a_level_o == 2'h0;
  endproperty
  a_pin_a_write: assert property (p_pin_a_write)
    else $error("Pin A field 01 did not give level zero.");

  property p_step_read;
    take && !we_i && adr_idx == IPLR_DEBUG_BREAK_STEP_PRIORITY
      |=> ack_o && dat_o[11:10] == $past(iplr_dbg_enc(step_counter_en_o,
                                                      step_counter_level_o))
          && dat_o[9:0] == 10'h000;
  endproperty
  a_step_read: assert property (p_step_read)
    else $error("Step counter readback is wrong.");

  property p_r1_reserved;
    take && !we_i && adr_idx == IPLR_DEBUG_TRANSFER_TRACE_PRIORITY
      |=> dat_o[31:6] == 26'h0000000;
  endproperty
  a_r1_reserved: assert property (p_r1_reserved)
    else $error("Reserved bits of register 1 read nonzero.");

  property p_r3_low;
    take && !we_i && adr_idx == IPLR_PORT_AND_CAN_PRIORITY
      |=> dat_o[1:0] == 2'h0 && dat_o[31:16] == 16'h0000;
  endproperty
  a_r3_low: assert property (p_r3_low)
    else $error("Reserved bits of register 3 read nonzero.");

  property p_hold;
    !wr_take |=> $stable(per_en) && $stable(dbg_en);
  endproperty
  a_hold: assert property (p_hold)
    else $error("A field changed without a write.");

  property p_ack_pulse;
    take |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("Ack is not a single cycle after the request.");

  property p_r0_reserved;
    take && !we_i && adr_idx == IPLR_DEBUG_BREAK_STEP_PRIORITY
      |=> dat_o[15:14] == 2'h0 && dat_o[31:16] == 16'h0000;
  endproperty
  a_r0_reserved: assert property (p_r0_reserved)
    else $error("Reserved bits of register 0 read nonzero.");

  property p_r2_reserved;
    take && !we_i && adr_idx == IPLR_FLASH_CLOCK_SUPPLY_PIN_PRIORITY
      |=> dat_o[5:4] == 2'h0 && dat_o[31:16] == 16'h0000;
  endproperty
  a_r2_reserved: assert property (p_r2_reserved)
    else $error("Reserved bits of register 2 read nonzero.");

  property p_rx_write;
    wr_take && adr_idx == IPLR_DEBUG_TRANSFER_TRACE_PRIORITY && sel_i[0]
      |=> (debug_rx_full_en_o ? debug_rx_full_level_o : 2'h0) == $past(dat_i[5:4]);
  endproperty
  a_rx_write: assert property (p_rx_write)
    else $error("Receive full level does not follow the write.");

  property p_tx_write;
    wr_take && adr_idx == IPLR_DEBUG_TRANSFER_TRACE_PRIORITY && sel_i[0]
      |=> (debug_tx_empty_en_o ? debug_tx_empty_level_o : 2'h0) == $past(dat_i[3:2]);
  endproperty
  a_tx_write: assert property (p_tx_write)
    else $error("Transmit empty level does not follow the write.");

  property p_trace_write;
    wr_take && adr_idx == IPLR_DEBUG_TRANSFER_TRACE_PRIORITY && sel_i[0]
      |=> (trace_buffer_en_o ? trace_buffer_level_o : 2'h0) == $past(dat_i[1:0]);
  endproperty
  a_trace_write: assert property (p_trace_write)
    else $error("Trace buffer level does not follow the write.");

  // Peripheral levels sit one below the field code, so the field is rebuilt
  // by adding one back before it is compared with what was written.
  property p_flash_empty_write;
    wr_take && adr_idx == IPLR_FLASH_CLOCK_SUPPLY_PIN_PRIORITY && sel_i[1]
      |=> (flash_buffers_empty_en_o ? flash_buffers_empty_level_o + 2'h1 : 2'h0)
          == $past(dat_i[15:14]);
  endproperty
  a_flash_empty_write: assert property (p_flash_empty_write)
    else $error("Flash buffers empty level does not follow the write.");

  property p_flash_done_write;
    wr_take && adr_idx == IPLR_FLASH_CLOCK_SUPPLY_PIN_PRIORITY && sel_i[1]
      |=> (flash_cmd_done_en_o ? flash_cmd_done_level_o + 2'h1 : 2'h0)
          == $past(dat_i[13:12]);
  endproperty
  a_flash_done_write: assert property (p_flash_done_write)
    else $error("Flash command done level does not follow the write.");

  property p_flash_fault_write;
    wr_take && adr_idx == IPLR_FLASH_CLOCK_SUPPLY_PIN_PRIORITY && sel_i[1]
      |=> (flash_fault_en_o ? flash_fault_level_o + 2'h1 : 2'h0)
          == $past(dat_i[11:10]);
  endproperty
  a_flash_fault_write: assert property (p_flash_fault_write)
    else $error("Flash fault level does not follow the write.");

  property p_pll_write;
    wr_take && adr_idx == IPLR_FLASH_CLOCK_SUPPLY_PIN_PRIORITY && sel_i[1]
      |=> (pll_unlocked_en_o ? pll_unlocked_level_o + 2'h1 : 2'h0)
          == $past(dat_i[9:8]);
  endproperty
  a_pll_write: assert property (p_pll_write)
    else $error("Pll unlocked level does not follow the write.");

  property p_supply_write;
    wr_take && adr_idx == IPLR_FLASH_CLOCK_SUPPLY_PIN_PRIORITY && sel_i[0]
      |=> (low_voltage_en_o ? low_voltage_level_o + 2'h1 : 2'h0)
          == $past(dat_i[7:6]);
  endproperty
  a_supply_write: assert property (p_supply_write)
    else $error("Low voltage level does not follow the write.");

  property p_pin_b_write;
    wr_take && adr_idx == IPLR_FLASH_CLOCK_SUPPLY_PIN_PRIORITY && sel_i[0]
      |=> (ext_pin_b_en_o ? ext_pin_b_level_o + 2'h1 : 2'h0)
          == $past(dat_i[3:2]);
  endproperty
  a_pin_b_write: assert property (p_pin_b_write)
    else $error("Pin B level does not follow the write.");

  property p_port_e_write;
    wr_take && adr_idx == IPLR_PORT_AND_CAN_PRIORITY && sel_i[1]
      |=> (port_e_en_o ? port_e_level_o + 2'h1 : 2'h0)
          == $past(dat_i[13:12]);
  endproperty
  a_port_e_write: assert property (p_port_e_write)
    else $error("Port E level does not follow the write.");

  property p_msgbuf_write;
    wr_take && adr_idx == IPLR_PORT_AND_CAN_PRIORITY && sel_i[1]
      |=> (can_msgbuf_en_o ? can_msgbuf_level_o + 2'h1 : 2'h0)
          == $past(dat_i[9:8]);
  endproperty
  a_msgbuf_write: assert property (p_msgbuf_write)
    else $error("Message buffer level does not follow the write.");

  property p_wake_write;
    wr_take && adr_idx == IPLR_PORT_AND_CAN_PRIORITY && sel_i[0]
      |=> (can_wake_en_o ? can_wake_level_o + 2'h1 : 2'h0)
          == $past(dat_i[7:6]);
  endproperty
  a_wake_write: assert property (p_wake_write)
    else $error("Wake level does not follow the write.");

  property p_busoff_write;
    wr_take && adr_idx == IPLR_PORT_AND_CAN_PRIORITY && sel_i[0]
      |=> (can_busoff_en_o ? can_busoff_level_o + 2'h1 : 2'h0)
          == $past(dat_i[3:2]);
  endproperty
  a_busoff_write: assert property (p_busoff_write)
    else $error("Bus off level does not follow the write.");

endmodule : iplr_regs

/* hw/iplr_pkg.sv */
package iplr_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int unsigned IPLR_ADR_W = 8;
  localparam int unsigned IPLR_DAT_W = 32;
  localparam int unsigned IPLR_SEL_W = 4;
  localparam int unsigned IPLR_IDX_W = 6;
  localparam int unsigned IPLR_LANE  = 8;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IPLR_DEBUG_BREAK_STEP_PRIORITY     = 6'h00;
  localparam logic [5:0] IPLR_DEBUG_TRANSFER_TRACE_PRIORITY = 6'h01;
  localparam logic [5:0] IPLR_FLASH_CLOCK_SUPPLY_PIN_PRIORITY = 6'h02;
  localparam logic [5:0] IPLR_PORT_AND_CAN_PRIORITY         = 6'h03;
  localparam logic [5:0] IPLR_LAST_IDX                      = 6'h03;

  // ==========================================================================
  // Field values
  localparam logic [1:0]  IPLR_FIELD_OFF = 2'h0;
  localparam logic [1:0]  IPLR_LVL_RST   = 2'h0;
  localparam logic [1:0]  IPLR_LVL_STEP  = 2'h1;
  localparam logic [31:0] IPLR_DAT_ZERO  = 32'h0000_0000;

  // ==========================================================================
  // Field tables: debug sources are breakpoint 0, step counter, receive full,
  // transmit empty and trace buffer, in that order.
  localparam int unsigned IPLR_NDBG = 5;
  localparam logic [5:0] IPLR_DBG_REG [IPLR_NDBG] = '{6'h00, 6'h00, 6'h01, 6'h01, 6'h01};
  localparam int unsigned IPLR_DBG_LSB [IPLR_NDBG] = '{12, 10, 4, 2, 0};

  // Peripheral sources: flash empty, flash done, flash fault, pll, supply,
  // pin b, pin a, port d, e, f, can buffer, wake, fault, bus off.
  localparam int unsigned IPLR_NPER = 14;
  localparam logic [5:0] IPLR_PER_REG [IPLR_NPER] = '{
    6'h02, 6'h02, 6'h02, 6'h02, 6'h02, 6'h02, 6'h02,
    6'h03, 6'h03, 6'h03, 6'h03, 6'h03, 6'h03, 6'h03};
  localparam int unsigned IPLR_PER_LSB [IPLR_NPER] = '{
    14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2};

  // ==========================================================================
  // Field coding
  function automatic logic [1:0] iplr_per_dec(input logic [1:0] field);
    iplr_per_dec = (field == IPLR_FIELD_OFF) ? IPLR_LVL_RST : field - IPLR_LVL_STEP;
  endfunction : iplr_per_dec

  function automatic logic [1:0] iplr_per_enc(input logic en, input logic [1:0] lvl);
    iplr_per_enc = en ? lvl + IPLR_LVL_STEP : IPLR_FIELD_OFF;
  endfunction : iplr_per_enc

  function automatic logic [1:0] iplr_dbg_enc(input logic en, input logic [1:0] lvl);
    iplr_dbg_enc = en ? lvl : IPLR_FIELD_OFF;
  endfunction : iplr_dbg_enc

endpackage : iplr_pkg

/* sim/iplr_arb_model.sv */
`timescale 1ns/10ps
// ==========================================================================
// Arbitration side model
// It turns each enable and numeric level back into the two-bit field code.
// A pair that the arbiter should never be handed, such as a disabled source
// with a nonzero level, clears its ok bit, so the bench sees that slip too.
module iplr_arb_model
  import iplr_pkg::*;
(
  input  wire logic [18:0]      en_i,
  input  wire logic [18:0][1:0] lv_i,
  output logic      [18:0][1:0] fld_o,
  output logic      [18:0]      ok_o
);
  always_comb begin
    for (int s = 0; s < 19; s++) begin
      if (!en_i[s]) begin
        fld_o[s] = IPLR_FIELD_OFF;
        ok_o[s]  = lv_i[s] == IPLR_LVL_RST;
      end else if (s < IPLR_NDBG) begin
        fld_o[s] = lv_i[s];
        ok_o[s]  = lv_i[s] != IPLR_LVL_RST;
      end else begin
        fld_o[s] = lv_i[s] + IPLR_LVL_STEP;
        ok_o[s]  = lv_i[s] != 2'h3;
      end
    end
  end
endmodule : iplr_arb_model

/* sim/iplr_regs_test.sv */
`timescale 1ns/10ps
// ==========================================================================
// Bench for the priority level registers
module iplr_regs_test
  import iplr_pkg::*;
;
  typedef struct packed {
    logic [5:0]  idx;
    logic [31:0] wd;
    logic [15:0] rd;
  } iplr_tb_row_t;

  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              we  = 1'b0;
  logic [7:0]        adr = 8'h00;
  logic [3:0]        sel = 4'h0;
  logic [31:0]       dat = 32'h0000_0000;
  logic [31:0]       dat_o;
  logic              ack;
  logic [18:0]       en;
  logic [18:0][1:0]  lv;
  logic [18:0][1:0]  fld;
  logic [18:0]       ok;
  logic [31:0]       q;
  logic [15:0]       m [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  int                fails = 0;
  int                comparisons = 0;
  // Writes of all ones show which bits are implemented; the two stripes
  // then set the fields of registers 0 and 2 to code 01 and those of registers 1 and 3 to code 10.
  iplr_tb_row_t      rows [8] = '{
    '{6'h00, 32'hFFFF_FFFF, 16'h3C00}, '{6'h01, 32'hFFFF_FFFF, 16'h003F},
    '{6'h02, 32'hFFFF_FFFF, 16'hFFCF}, '{6'h03, 32'hFFFF_FFFF, 16'hFFFC},
    '{6'h00, 32'h5555_5555, 16'h1400}, '{6'h01, 32'hAAAA_AAAA, 16'h002A},
    '{6'h02, 32'h5555_5555, 16'h5545}, '{6'h03, 32'hAAAA_AAAA, 16'hAAA8}};

  always #10 clk = ~clk;

  iplr_regs uut (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
    .breakpoint0_en_o(en[0]), .breakpoint0_level_o(lv[0]),
    .step_counter_en_o(en[1]), .step_counter_level_o(lv[1]),
    .debug_rx_full_en_o(en[2]), .debug_rx_full_level_o(lv[2]),
    .debug_tx_empty_en_o(en[3]), .debug_tx_empty_level_o(lv[3]),
    .trace_buffer_en_o(en[4]), .trace_buffer_level_o(lv[4]),
    .flash_buffers_empty_en_o(en[5]), .flash_buffers_empty_level_o(lv[5]),
    .flash_cmd_done_en_o(en[6]), .flash_cmd_done_level_o(lv[6]),
    .flash_fault_en_o(en[7]), .flash_fault_level_o(lv[7]),
    .pll_unlocked_en_o(en[8]), .pll_unlocked_level_o(lv[8]),
    .low_voltage_en_o(en[9]), .low_voltage_level_o(lv[9]),
    .ext_pin_b_en_o(en[10]), .ext_pin_b_level_o(lv[10]),
    .ext_pin_a_en_o(en[11]), .ext_pin_a_level_o(lv[11]),
    .port_d_en_o(en[12]), .port_d_level_o(lv[12]),
    .port_e_en_o(en[13]), .port_e_level_o(lv[13]),
    .port_f_en_o(en[14]), .port_f_level_o(lv[14]),
    .can_msgbuf_en_o(en[15]), .can_msgbuf_level_o(lv[15]),
    .can_wake_en_o(en[16]), .can_wake_level_o(lv[16]),
    .can_fault_en_o(en[17]), .can_fault_level_o(lv[17]),
    .can_busoff_en_o(en[18]), .can_busoff_level_o(lv[18])
  );

  iplr_arb_model arb (
    .en_i(en),
    .lv_i(lv),
    .fld_o(fld),
    .ok_o(ok)
  );

  // ==========================================================================
  // Tasks
  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One classic cycle; the slave may take as long as it likes up to the bound.
  task automatic wb(input logic w, input logic [5:0] i, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {i, 2'h0};
    sel <= s;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = dat_o;
    if (n >= 50) begin
      fails++;
      end_sim();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  function automatic logic [1:0] exp_fld(input int s);
    if (s < IPLR_NDBG) exp_fld = m[IPLR_DBG_REG[s]][IPLR_DBG_LSB[s] +: 2];
    else exp_fld = m[IPLR_PER_REG[s - IPLR_NDBG]][IPLR_PER_LSB[s - IPLR_NDBG] +: 2];
  endfunction : exp_fld

  task automatic chk_fields();
    for (int s = 0; s < 19; s++) begin
      if (s < 5) chk("debug field", {30'h0, exp_fld(s)}, {30'h0, fld[s]});
      else if (s < 12) chk("reg2 field", {30'h0, exp_fld(s)}, {30'h0, fld[s]});
      else chk("reg3 field", {30'h0, exp_fld(s)}, {30'h0, fld[s]});
      chk("level pair", 32'h0000_0001, {31'h0, ok[s]});
    end
  endtask : chk_fields

  // ==========================================================================
  // Sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 6'(i), 4'hF, 32'h0000_0000, q);
      chk("reset read", 32'h0000_0000, q);
    end
    chk_fields();
    $display("test reset done");
    foreach (rows[k]) begin
      wb(1'b1, rows[k].idx, 4'hF, rows[k].wd, q);
      wb(1'b0, rows[k].idx, 4'hF, 32'h0000_0000, q);
      chk("readback", {16'h0000, rows[k].rd}, q);
      m[rows[k].idx[1:0]] = rows[k].rd;
      chk_fields();
    end
    $display("test table done");
    // Only the low byte lane is enabled, so the upper fields must survive.
    wb(1'b1, 6'h02, 4'h1, 32'h0000_0000, q);
    m[2] = m[2] & 16'hFF00;
    wb(1'b0, 6'h02, 4'hF, 32'h0000_0000, q);
    chk("lane read", {16'h0000, m[2]}, q);
    chk_fields();
    $display("test lanes done");
    wb(1'b1, 6'h05, 4'hF, 32'hFFFF_FFFF, q);
    wb(1'b0, 6'h05, 4'hF, 32'h0000_0000, q);
    chk("unmapped read", 32'h0000_0000, q);
    chk_fields();
    $display("test unmapped done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    m = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    @(posedge clk);
    chk_fields();
    wb(1'b0, 6'h03, 4'hF, 32'h0000_0000, q);
    chk("second reset read", 32'h0000_0000, q);
    $display("test second reset done");
    end_sim();
  end
endmodule : iplr_regs_test
